// *** dv/msd_decoder_monitor.sv ***
// msd_decoder_monitor.sv: port-level timing checks of the decoder.
// assumes: bound to msd_decoder, single clock, async active-low reset.
`timescale 1ns/10ps
module msd_decoder_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic acc_req,
    input wire logic [2:0] acc_kind,
    input wire logic acc_write,
    input wire logic [7:0] acc_addr,
    input wire logic [2:0] acc_reg_num,
    input wire logic [6:0] acc_bit_num,
    input wire logic [7:0] psw,
    input wire logic [15:0] data_pointer,
    input wire logic irq_take,
    input wire logic [2:0] irq_src,
    input wire logic int_ram_sel,
    input wire logic [7:0] int_ram_addr,
    input wire logic upper_ram_sel,
    input wire logic sfr_sel,
    input wire logic bit_sel,
    input wire logic [7:0] bit_byte_addr,
    input wire logic [2:0] bit_index,
    input wire logic sfr_bit_ok,
    input wire logic [15:0] ext_addr,
    input wire logic program_fetch_strobe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic fetch_word,
    input wire logic [15:0] program_counter,
    input wire logic mcycle_end
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
// ============================================================
// internal space
a_lower_ram: assert property (
    acc_req && acc_kind <= 3'h1 && !acc_addr[7] |=>
    int_ram_sel && int_ram_addr == $past(acc_addr)) else $error("lower ram");
a_direct_sfr: assert property (
    acc_req && acc_kind == 3'h0 && acc_addr[7] |=>
    sfr_sel && !upper_ram_sel) else $error("direct upper");
a_indirect_upper: assert property (
    acc_req && (acc_kind == 3'h1 || acc_kind == 3'h2) && acc_addr[7] |=>
    upper_ram_sel && !sfr_sel) else $error("indirect upper");
a_bank_reg: assert property (
    acc_req && acc_kind == 3'h4 |=>
    int_ram_addr == {3'h0, $past(psw[4:3]), $past(acc_reg_num)})
    else $error("bank address");
a_bit_area: assert property (
    acc_req && acc_kind == 3'h3 && !acc_addr[7] |=>
    bit_sel && bit_byte_addr == 8'h20 + $past(acc_bit_num[6:3])
    && bit_index == $past(acc_bit_num[2:0])) else $error("bit area");
a_sfr_bit: assert property (
    acc_req && acc_kind == 3'h3 && acc_addr[7] |=>
    sfr_bit_ok == ($past(acc_addr[2:0]) == 3'h0)
    && sfr_sel == ($past(acc_addr[2:0]) == 3'h0)) else $error("sfr bit");
// ============================================================
// external space and program flow
a_ext_data: assert property (
    acc_req && acc_kind == 3'h5 |=> ext_addr == $past(data_pointer)
    && rd_n == $past(acc_write) && wr_n == !$past(acc_write))
    else $error("ext strobe");
a_no_ext_strobe: assert property (
    acc_req && acc_kind < 3'h5 |=> rd_n && wr_n) else $error("int strobe");
a_irq_vector: assert property (
    irq_take |=> program_counter == 16'h0003 + {10'h0, $past(irq_src), 3'h0})
    else $error("vector");
a_reset_pc: assert property (
    $rose(rst_n) |-> program_counter == 16'h0000) else $error("reset pc");
a_fetch_step: assert property (
    $fell(program_fetch_strobe_n) |-> fetch_word
    && program_counter == $past(program_counter) + 16'h0002)
    else $error("fetch step");
a_mcycle_four: assert property (
    mcycle_end |=> !mcycle_end [*3] ##1 mcycle_end) else $error("mcycle");
endmodule // msd_decoder_monitor

bind msd_decoder msd_decoder_monitor msd_decoder_monitor_inst (.clk, .rst_n,
    .acc_req, .acc_kind, .acc_write, .acc_addr, .acc_reg_num, .acc_bit_num,
    .psw, .data_pointer, .irq_take, .irq_src, .int_ram_sel, .int_ram_addr,
    .upper_ram_sel, .sfr_sel, .bit_sel, .bit_byte_addr, .bit_index,
    .sfr_bit_ok, .ext_addr, .program_fetch_strobe_n, .rd_n, .wr_n,
    .fetch_word, .program_counter, .mcycle_end);

// *** dv/msd_ext_mem.sv ***
// msd_ext_mem.sv: external memory side, placement straps and override.
// assumes: same clock and reset as the decoder.
`timescale 1ns/10ps
module msd_ext_mem #(
    parameter MAIN_P = 1'b1,
    parameter MAIN_D = 1'b1,
    parameter SEC_P = 1'b0,
    parameter SEC_D = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic upd,
    input wire logic rd_n,
    input wire logic wr_n,
    output wire logic place_main_prog,
    output wire logic place_main_data,
    output wire logic place_sec_prog,
    output wire logic place_sec_data,
    output logic ovr_en,
    output logic ovr_main_data,
    output logic ovr_sec_data,
    output logic [7:0] hits
);
// straps are fixed like non-volatile settings
assign place_main_prog = MAIN_P;
assign place_main_data = MAIN_D;
assign place_sec_prog = SEC_P;
assign place_sec_data = SEC_D;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ovr_en <= 1'b0;
        ovr_main_data <= 1'b0;
        ovr_sec_data <= 1'b0;
        hits <= 8'h00;
    end else begin
        ovr_en <= upd;
        ovr_main_data <= upd;
        ovr_sec_data <= upd;
        // counts every external strobe, internal accesses must add none
        hits <= hits + {7'h00, !rd_n || !wr_n};
    end
end
endmodule // msd_ext_mem

// *** dv/testbench.sv ***
// testbench.sv: directed scenarios for the memory space decoder.
// assumes: design files under rtl/, monitor bound to msd_decoder.
`timescale 1ns/10ps
module testbench;
logic clk = 1'b0, rst_n = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
logic fetch_req = 1'b0, jump_req = 1'b0, irq_take = 1'b0, upd = 1'b0;
logic [2:0] acc_kind = 3'h0, acc_reg_num = 3'h0, irq_src = 3'h0;
logic [2:0] mcycles = 3'h1, bit_index;
logic [6:0] acc_bit_num = 7'h00;
logic [7:0] acc_addr = 8'h00, psw = 8'h00, int_ram_addr, sfr_addr;
logic [7:0] bit_byte_addr, hits, h;
logic [15:0] data_pointer = 16'h0000, jump_addr = 16'h1234, p;
logic [15:0] ext_addr, program_counter;
logic place_main_prog, place_main_data, place_sec_prog, place_sec_data;
logic ovr_en, ovr_main_data, ovr_sec_data, acc_done, int_ram_sel;
logic upper_ram_sel, sfr_sel, bit_sel, sfr_bit_ok, program_fetch_strobe_n;
logic rd_n, wr_n, fetch_word, main_flash_prog, main_flash_data;
logic sec_flash_prog, sec_flash_data, sram_data_en, csr_data_en;
logic mcycle_end, instr_done;
int errors = 0, checked = 0, cycles = 0, n;
logic [2:0] tk [6] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h2};
logic [7:0] ta [6] = '{8'h30, 8'h7f, 8'hff, 8'h80, 8'h80, 8'h20};
logic [2:0] te [6] = '{3'h4, 3'h4, 3'h6, 3'h6, 3'h1, 3'h4};
msd_decoder msd_decoder_inst (.*);
msd_ext_mem msd_ext_mem_inst (.*);
always #5 clk = ~clk;
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
        errors = errors + 1;
        end_of_test;
    end
end
// ============================================================
// shared tasks
task chk(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task acc(input logic [2:0] k, input logic [7:0] a, input logic w);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_kind <= k;
    acc_addr <= a;
    acc_write <= w;
    @(posedge clk);
    acc_req <= 1'b0;
    #1;
endtask
task wait_fetch;
    n = 0;
    do begin
        @(posedge clk);
        #1;
        n = n + 1;
    end while (program_fetch_strobe_n !== 1'b0 && n < 9);
endtask
task pulse(input logic i, input logic j, input logic [2:0] s,
    input logic [15:0] exp);
    @(posedge clk);
    irq_take <= i;
    jump_req <= j;
    irq_src <= s;
    @(posedge clk);
    irq_take <= 1'b0;
    jump_req <= 1'b0;
    #1;
    chk(program_counter, exp);
endtask
task end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// ============================================================
// scenarios
task t_reset;
    repeat (3) @(posedge clk);
    #1;
    chk(program_counter, 16'h0000);
    chk({main_flash_prog, main_flash_data, sec_flash_prog, sec_flash_data},
        16'h000d);
    chk({sram_data_en, csr_data_en}, 16'h0003);
    $display("reset test done");
endtask
task t_internal;
    h = hits;
    for (int i = 0; i < 6; i++) begin
        acc(tk[i], ta[i], 1'b0);
        chk({int_ram_sel, upper_ram_sel, sfr_sel}, te[i]);
        chk({acc_done, rd_n, wr_n}, 16'h0007);
    end
    for (int b = 0; b < 4; b++) begin
        @(posedge clk);
        psw <= {3'h0, b[1:0], 3'h0};
        acc_reg_num <= 3'h7;
        acc(3'h4, 8'h00, 1'b0);
        chk(int_ram_addr, {b[1:0], 3'h7});
    end
    chk(hits, h);
    $display("internal test done");
endtask
task t_bits;
    @(posedge clk);
    acc_bit_num <= 7'h3f;
    acc(3'h3, 8'h00, 1'b0);
    chk({bit_sel, bit_byte_addr, bit_index}, {4'h0, 1'b1, 8'h27, 3'h7});
    @(posedge clk);
    acc_bit_num <= 7'h7f;
    acc(3'h3, 8'h00, 1'b0);
    chk({bit_sel, bit_byte_addr, bit_index}, {4'h0, 1'b1, 8'h2f, 3'h7});
    @(posedge clk);
    acc_bit_num <= 7'h40;
    // only implemented register addresses are touched
    acc(3'h3, 8'hf0, 1'b0);
    chk(sfr_bit_ok, 16'h0001);
    chk({bit_sel, sfr_sel, sfr_addr}, 16'h03f0);
    acc(3'h3, 8'h8c, 1'b0);
    chk(sfr_bit_ok, 16'h0000);
    chk({bit_sel, sfr_sel, sfr_addr}, 16'h028c);
    $display("bit test done");
endtask
task t_ext;
    @(posedge clk);
    data_pointer <= 16'hfffe;
    h = hits;
    acc(3'h5, 8'h00, 1'b0);
    chk({rd_n, wr_n}, 16'h0001);
    chk(ext_addr, 16'hfffe);
    acc(3'h5, 8'h00, 1'b1);
    chk({rd_n, wr_n}, 16'h0002);
    @(posedge clk);
    #1;
    chk(hits, h + 8'h02);
    $display("external test done");
endtask
task t_fetch;
    @(posedge clk);
    fetch_req <= 1'b1;
    wait_fetch;
    p = program_counter;
    wait_fetch;
    chk(n, 16'h0004);
    chk(program_counter, p + 16'h0002);
    @(posedge clk);
    fetch_req <= 1'b0;
    $display("fetch test done");
endtask
task t_vectors;
    pulse(1'b1, 1'b0, 3'h0, 16'h0003);
    pulse(1'b1, 1'b0, 3'h1, 16'h000b);
    pulse(1'b0, 1'b1, 3'h0, 16'h1234);
    pulse(1'b1, 1'b1, 3'h2, 16'h0013);
    $display("vector test done");
endtask
task t_update;
    @(posedge clk);
    upd <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({main_flash_prog, main_flash_data, sec_flash_prog, sec_flash_data},
        16'h0005);
    @(posedge clk);
    upd <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({main_flash_prog, main_flash_data, sec_flash_prog, sec_flash_data},
        16'h000d);
    $display("update test done");
endtask
task t_timing;
    for (int m = 1; m < 5; m = m * 2) begin
        @(posedge clk);
        mcycles <= m[2:0];
        // first done may still belong to the old count
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n = n + 1;
            end while (instr_done !== 1'b1 && n < 40);
        end
        chk(n, 4 * m);
    end
    $display("timing test done");
endtask
initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_internal;
    t_bits;
    t_ext;
    t_fetch;
    t_vectors;
    t_update;
    t_timing;
    end_of_test;
end
endmodule // testbench

// *** rtl/msd_decoder.v ***
// msd_decoder.v: memory space decoder of the core.
// assumes: the core presents one access at a time and holds it
// until acc_done; the external decode module drives placement straps.
//
// Functional notes
// - lower 128 internal bytes reachable by direct and indirect access.
// - four register banks of eight at 0x00-0x1f, one active.
// - bytes 0x20-0x2f hold 128 bit-addressable flags.
// - indirect 0x80-0xff goes to upper RAM, never direct.
// - stack accesses are indirect across all 256 bytes.
// - direct 0x80-0xff reaches special function registers.
// - special function regs ending in hex 0 or 8 are bit-addressable.
// - fetches use the program counter and assert the fetch strobe.
// - after reset execution starts at program address 0x0000.
// - taken interrupt jumps to fixed vector, eight bytes apart.
// - external data uses the data pointer with read/write strobes.
// - internal RAM accesses never assert external strobes.
// - external SRAM and control block decode in data space only.
// - each flash goes to program, data or both per straps at reset.
// - firmware may override flash placement to data space at run time.
// - machine cycle lasts four core clocks.
// - opcode lengths and cycle counts stay standard.
// - program path is 16 bits wide, two bytes per access.
`timescale 1ns/10ps
`include "msd_regs.vh"
module msd_decoder (
    clk,
    rst_n,
    acc_req,
    acc_kind,
    acc_write,
    acc_addr,
    acc_reg_num,
    acc_bit_num,
    psw,
    data_pointer,
    fetch_req,
    jump_req,
    jump_addr,
    irq_take,
    irq_src,
    mcycles,
    place_main_prog,
    place_main_data,
    place_sec_prog,
    place_sec_data,
    ovr_en,
    ovr_main_data,
    ovr_sec_data,
    acc_done,
    int_ram_sel,
    int_ram_addr,
    upper_ram_sel,
    sfr_sel,
    sfr_addr,
    bit_sel,
    bit_byte_addr,
    bit_index,
    sfr_bit_ok,
    ext_addr,
    program_fetch_strobe_n,
    rd_n,
    wr_n,
    fetch_word,
    program_counter,
    main_flash_prog,
    main_flash_data,
    sec_flash_prog,
    sec_flash_data,
    sram_data_en,
    csr_data_en,
    mcycle_end,
    instr_done
);
input wire clk;
input wire rst_n;
input wire acc_req;
input wire [2:0] acc_kind;
input wire acc_write;
input wire [7:0] acc_addr;
input wire [2:0] acc_reg_num;
input wire [6:0] acc_bit_num;
input wire [7:0] psw;
input wire [15:0] data_pointer;
input wire fetch_req;
input wire jump_req;
input wire [15:0] jump_addr;
input wire irq_take;
input wire [2:0] irq_src;
input wire [2:0] mcycles;
input wire place_main_prog;
input wire place_main_data;
input wire place_sec_prog;
input wire place_sec_data;
input wire ovr_en;
input wire ovr_main_data;
input wire ovr_sec_data;
output reg acc_done;
output reg int_ram_sel;
output reg [7:0] int_ram_addr;
output reg upper_ram_sel;
output reg sfr_sel;
output reg [7:0] sfr_addr;
output reg bit_sel;
output reg [7:0] bit_byte_addr;
output reg [2:0] bit_index;
output reg sfr_bit_ok;
output reg [15:0] ext_addr;
output reg program_fetch_strobe_n;
output reg rd_n;
output reg wr_n;
output reg fetch_word;
output reg [15:0] program_counter;
output reg main_flash_prog;
output reg main_flash_data;
output reg sec_flash_prog;
output reg sec_flash_data;
output wire sram_data_en;
output wire csr_data_en;
output wire mcycle_end;
output reg instr_done;

// ============================================================
// helpers
function sfr_bit_addressable;
    input [7:0] a;
    begin
        sfr_bit_addressable = a[7] && (a[2:0] == 3'h0);
    end
endfunction

function is_lower;
    input [7:0] a;
    begin
        is_lower = (a <= `MSD_LOWER_RAM_TOP);
    end
endfunction

// ============================================================
// machine cycle and vectors
wire [1:0] phase;
wire [15:0] irq_vector;

msd_mcycle u_mcycle (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase),
    .mcycle_end(mcycle_end)
);

msd_vector u_vector (
    .src(irq_src),
    .vector(irq_vector)
);

// ============================================================
// placement: straps captured after reset release, override at run time
reg strap_taken;
reg main_prog_strap;
reg main_data_strap;
reg sec_prog_strap;
reg sec_data_strap;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        strap_taken <= 1'b0;
        main_prog_strap <= 1'b0;
        main_data_strap <= 1'b0;
        sec_prog_strap <= 1'b0;
        sec_data_strap <= 1'b0;
    end else if (!strap_taken) begin
        // caught on the first edge after release, held until next reset
        strap_taken <= 1'b1;
        main_prog_strap <= place_main_prog;
        main_data_strap <= place_main_data;
        sec_prog_strap <= place_sec_prog;
        sec_data_strap <= place_sec_data;
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        main_flash_prog <= 1'b0;
        main_flash_data <= 1'b0;
        sec_flash_prog <= 1'b0;
        sec_flash_data <= 1'b0;
    end else if (ovr_en && strap_taken) begin
        // update path: a reclassified flash leaves program space
        main_flash_prog <= main_prog_strap && !ovr_main_data;
        main_flash_data <= main_data_strap || ovr_main_data;
        sec_flash_prog <= sec_prog_strap && !ovr_sec_data;
        sec_flash_data <= sec_data_strap || ovr_sec_data;
    end else begin
        main_flash_prog <= main_prog_strap;
        main_flash_data <= main_data_strap;
        sec_flash_prog <= sec_prog_strap;
        sec_flash_data <= sec_data_strap;
    end
end

// sram and control block never see program space
assign sram_data_en = 1'b1;
assign csr_data_en = 1'b1;

// ============================================================
// program counter and fetch
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        program_counter <= `MSD_RESET_VECTOR;
        program_fetch_strobe_n <= 1'b1;
        fetch_word <= 1'b0;
    end else begin
        program_fetch_strobe_n <= 1'b1;
        fetch_word <= 1'b0;
        if (irq_take) begin
            program_counter <= irq_vector;
        end else if (jump_req) begin
            program_counter <= jump_addr;
        end else if (fetch_req && mcycle_end) begin
            // one access returns two code bytes
            program_fetch_strobe_n <= 1'b0;
            fetch_word <= 1'b1;
            program_counter <= program_counter + 16'h0002;
        end
    end
end

// ============================================================
// instruction timing: native machine-cycle counts, four clocks each
reg [2:0] mc_left;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        mc_left <= 3'h0;
        instr_done <= 1'b0;
    end else begin
        instr_done <= 1'b0;
        if (mcycle_end) begin
            if (mc_left == 3'h0) begin
                // the idle cycle is already the first machine cycle
                if (mcycles == 3'h1) begin
                    instr_done <= 1'b1;
                end else if (mcycles != 3'h0) begin
                    mc_left <= mcycles - 3'h1;
                end
            end else if (mc_left == 3'h1) begin
                mc_left <= 3'h0;
                instr_done <= 1'b1;
            end else begin
                mc_left <= mc_left - 3'h1;
            end
        end
    end
end

// ============================================================
// data access decode
reg next_int_ram_sel;
reg [7:0] next_int_ram_addr;
reg next_upper_sel;
reg next_sfr_sel;
reg next_bit_sel;
reg [7:0] next_bit_byte;
reg next_ext;
reg [7:0] bank_base;

always @* begin
    bank_base = {3'h0, psw[`MSD_BANK_SEL_MSB:`MSD_BANK_SEL_LSB], 3'h0};
    next_int_ram_sel = 1'b0;
    next_int_ram_addr = 8'h00;
    next_upper_sel = 1'b0;
    next_sfr_sel = 1'b0;
    next_bit_sel = 1'b0;
    next_bit_byte = 8'h00;
    next_ext = 1'b0;
    case (acc_kind)
        `MSD_ACC_DIRECT: begin
            if (is_lower(acc_addr)) begin
                next_int_ram_sel = 1'b1;
                next_int_ram_addr = acc_addr;
            end else begin
                next_sfr_sel = 1'b1;
            end
        end
        `MSD_ACC_INDIRECT, `MSD_ACC_STACK: begin
            // stack runs straight across 0x7f/0x80 in one ram
            next_int_ram_sel = 1'b1;
            next_int_ram_addr = acc_addr;
            next_upper_sel = !is_lower(acc_addr);
        end
        `MSD_ACC_REG: begin
            next_int_ram_sel = 1'b1;
            next_int_ram_addr = bank_base | {5'h00, acc_reg_num};
        end
        `MSD_ACC_BIT: begin
            next_bit_sel = 1'b1;
            // acc_addr names the register; low space keeps all 128 flags
            if (!acc_addr[7]) begin
                next_bit_byte = `MSD_BIT_BYTE_LO
                    | {4'h0, acc_bit_num[6:3]};
                next_int_ram_sel = 1'b1;
                next_int_ram_addr = next_bit_byte;
            end else begin
                next_bit_byte = {acc_addr[7:3], 3'h0};
                // a register off the eight-byte grid gets no select
                next_sfr_sel = sfr_bit_addressable(acc_addr);
            end
        end
        `MSD_ACC_EXTERNAL_DATA_SPACE: begin
            next_ext = 1'b1;
        end
        default: begin
            next_ext = 1'b0;
        end
    endcase
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        acc_done <= 1'b0;
        int_ram_sel <= 1'b0;
        int_ram_addr <= 8'h00;
        upper_ram_sel <= 1'b0;
        sfr_sel <= 1'b0;
        sfr_addr <= 8'h00;
        bit_sel <= 1'b0;
        bit_byte_addr <= 8'h00;
        bit_index <= 3'h0;
        sfr_bit_ok <= 1'b0;
        ext_addr <= 16'h0000;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
    end else begin
        acc_done <= acc_req;
        int_ram_sel <= acc_req && next_int_ram_sel;
        int_ram_addr <= next_int_ram_addr;
        upper_ram_sel <= acc_req && next_upper_sel;
        sfr_sel <= acc_req && next_sfr_sel;
        sfr_addr <= acc_addr;
        bit_sel <= acc_req && next_bit_sel;
        bit_byte_addr <= next_bit_byte;
        bit_index <= acc_bit_num[2:0];
        sfr_bit_ok <= sfr_bit_addressable(acc_addr);
        ext_addr <= data_pointer;
        // strobes only for external data, never for internal ram
        rd_n <= !(acc_req && next_ext && !acc_write);
        wr_n <= !(acc_req && next_ext && acc_write);
    end
end
endmodule // msd_decoder

// *** rtl/msd_mcycle.v ***
// msd_mcycle.v: machine-cycle phase counter, one strobe per four clocks.
// assumes: free running clock, asynchronous active-low reset.
`timescale 1ns/10ps
`include "msd_regs.vh"
module msd_mcycle (
    clk,
    rst_n,
    phase,
    mcycle_end
);
input wire clk;
input wire rst_n;
output reg [1:0] phase;
output wire mcycle_end;

// ============================================================
// phase counter
assign mcycle_end = (phase == 2'h3);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        phase <= 2'h0;
    end else begin
        // wraps naturally after four clocks
        phase <= phase + 2'h1;
    end
end
endmodule // msd_mcycle

// *** rtl/msd_regs.vh ***
// msd_regs.vh: address map, vectors and timing constants of the decoder.
// assumes: included by bare name from the rtl/ design files.
`ifndef MSD_REGS_VH
`define MSD_REGS_VH
// ============================================================
// internal space
`define MSD_LOWER_RAM_TOP 8'h7f
`define MSD_BANK_TOP 8'h1f
`define MSD_BIT_BYTE_LO 8'h20
`define MSD_BIT_BYTE_HI 8'h2f
`define MSD_BANK_SEL_LSB 3
`define MSD_BANK_SEL_MSB 4
// ============================================================
// program space vectors
`define MSD_RESET_VECTOR 16'h0000
`define MSD_VEC_EXT_ZERO 16'h0003
`define MSD_VEC_TIMER_ZERO 16'h000b
`define MSD_VEC_EXT_ONE 16'h0013
// ============================================================
// machine cycle
`define MSD_CLKS_PER_MCYCLE 3'h4
// ============================================================
// access kinds
`define MSD_ACC_DIRECT 3'h0
`define MSD_ACC_INDIRECT 3'h1
`define MSD_ACC_STACK 3'h2
`define MSD_ACC_BIT 3'h3
`define MSD_ACC_REG 3'h4
`define MSD_ACC_EXTERNAL_DATA_SPACE 3'h5
`endif

// *** rtl/msd_vector.v ***
// msd_vector.v: interrupt vector lookup, eight bytes per source.
// assumes: source number settles before the core takes the interrupt.
`timescale 1ns/10ps
`include "msd_regs.vh"
module msd_vector (
    src,
    vector
);
input wire [2:0] src;
output wire [15:0] vector;

// ============================================================
// 0x0003 + 8*source
assign vector = `MSD_VEC_EXT_ZERO + {10'h000, src, 3'h0};
endmodule // msd_vector
